// ==== timer2_ctrl.sv ====
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// - outside up/down mode, a trigger-pin falling edge that captures or reloads sets the external event flag.
// - outside up/down mode, an enabled timer interrupt with the external event flag set raises the interrupt.
// - in up/down mode the external event flag raises no interrupt.
// - with rx select set the receiver baud clock is this timer's overflow, else timer 1.
// - with tx select set the transmitter baud clock is this timer's overflow, else timer 1.
// - trigger edges act only while the timer is not the serial baud clock.
// - with trigger enable clear, trigger pin events are ignored.
// - run control starts counting when 1 and stops it when 0.
// - counter mode 0 counts osc/12, mode 1 counts event input falling edges.
// - capture select with trigger enable captures the count on each trigger fall.
// - reload mode reloads on overflow, and also on trigger fall when enabled outside up/down mode.
// - while rx or tx select is 1 the overflow flag is not set.
// - with rx and tx select both 0, each overflow sets the overflow flag, cleared by software.
// - in up/down mode each over- or underflow toggles the external event flag.
module timer2_ctrl #(
	parameter int width = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic trigger_input_pin,
	input wire logic event_input_pin,
	input wire logic timer1_overflow,
	input wire logic timer2_irq_enable,
	output timer2_pkg::baud_ticks_t baud_ticks,
	output logic irq
);
	import timer2_pkg::*;

	timer2_control_t ctrl_r;
	logic [1:0] mode_r;
	logic [width-1:0] count_r, reload_r, capture_r;
	logic [1:0] stat_r, mask_r;
	logic [3:0] presc_r;
	logic [7:0] aw_addr_r, ar_addr_r;
	logic aw_have_r, w_have_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [31:0] rd_nxt;
	logic trig_fall, evt_fall, tick, baud_mode, trig_act, wr_go;
	logic at_top, at_bot, ovf, unf, wrap;
	logic ovf_set, ext_set, ext_tgl;

	// ====================================================
	// edge detection
	fall_detect u_trig (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.din(trigger_input_pin),
		.fall(trig_fall)
	);
	fall_detect u_evt (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.din(event_input_pin),
		.fall(evt_fall)
	);

	// ====================================================
	// count engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_r <= 4'h0;
		end else if (ce) begin
			if (presc_r == 4'(osc_div - 1)) begin
				presc_r <= 4'h0;
			end else begin
				presc_r <= presc_r + 4'h1;
			end
		end
	end

	assign baud_mode = ctrl_r.rx_baud_source_select || ctrl_r.tx_baud_source_select;
	// external trigger only when enabled and not feeding the serial port
	assign trig_act = trig_fall && ctrl_r.external_trigger_enable && !baud_mode;
	assign tick = ctrl_r.run_control && (ctrl_r.counter_mode_select ? evt_fall
		: (presc_r == 4'(osc_div - 1)));
	assign at_top = count_r == {width{1'b1}};
	assign at_bot = count_r == reload_r;
	assign ovf = tick && at_top && !(mode_r[updown_bit] && !mode_r[dir_bit]);
	assign unf = tick && mode_r[updown_bit] && !mode_r[dir_bit] && at_bot;
	assign wrap = ovf || unf;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= '0;
		end else if (ce) begin
			if (wr_go && aw_addr_r == count_off) begin
				count_r <= wdata_r[width-1:0];
			end else if (trig_act && !ctrl_r.capture_reload_select && !mode_r[updown_bit]) begin
				count_r <= reload_r;
			end else if (ovf && (!ctrl_r.capture_reload_select || baud_mode)) begin
				count_r <= reload_r;
			end else if (unf) begin
				count_r <= {width{1'b1}};
			end else if (tick && mode_r[updown_bit] && !mode_r[dir_bit]) begin
				count_r <= count_r - width'(1);
			end else if (tick) begin
				count_r <= count_r + width'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_r <= '0;
		end else if (ce && trig_act && ctrl_r.capture_reload_select) begin
			capture_r <= count_r;
		end
	end

	// ====================================================
	// flags: hardware set wins over a software clear in the same cycle
	assign ovf_set = ovf && !baud_mode;
	assign ext_set = trig_act && !mode_r[updown_bit];
	assign ext_tgl = wrap && mode_r[updown_bit];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= timer2_control_t'(ctrl_reset);
		end else if (ce) begin
			if (wr_go && aw_addr_r == ctrl_off && wstrb_r[0]) begin
				ctrl_r <= timer2_control_t'(wdata_r[7:0]);
			end
			if (ovf_set) begin
				ctrl_r.overflow_flag <= 1'b1;
			end
			// no clear on interrupt entry; software writes it to zero
			if (ext_set) begin
				ctrl_r.external_event_flag <= 1'b1;
			end else if (ext_tgl) begin
				ctrl_r.external_event_flag <= ~ctrl_r.external_event_flag;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= mode_reset;
			reload_r <= '0;
			mask_r <= 2'h0;
		end else if (ce && wr_go) begin
			if (aw_addr_r == mode_off) begin
				mode_r <= wdata_r[1:0];
			end
			if (aw_addr_r == reload_off) begin
				reload_r <= wdata_r[width-1:0];
			end
			if (aw_addr_r == irq_mask_off) begin
				mask_r <= wdata_r[1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_r <= 2'h0;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				if (wr_go && aw_addr_r == irq_stat_off && wdata_r[i]) begin
					stat_r[i] <= 1'b0;
				end
			end
			if (ovf_set) begin
				stat_r[irq_ovf_bit] <= 1'b1;
			end
			if (ext_set) begin
				stat_r[irq_ext_bit] <= 1'b1;
			end
		end
	end

	// ====================================================
	// interrupt and baud outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
			baud_ticks <= '0;
		end else if (ce) begin
			irq <= (|(stat_r & mask_r)) || (timer2_irq_enable
				&& (ctrl_r.overflow_flag
				|| (ctrl_r.external_event_flag && !mode_r[updown_bit])));
			baud_ticks.rx_tick <= ctrl_r.rx_baud_source_select ? ovf : timer1_overflow;
			baud_ticks.tx_tick <= ctrl_r.tx_baud_source_select ? ovf : timer1_overflow;
		end
	end

	// ====================================================
	// axi4-lite slave: one write and one read at a time
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else if (ce) begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_r <= irq_mask_off && aw_addr_r[1:0] == 2'h0
					&& aw_addr_r != capture_off) ? resp_okay : resp_slverr;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_nxt = 32'h0;
		case (ar_addr_r)
			ctrl_off: rd_nxt = {24'h0, ctrl_r};
			reload_off: rd_nxt = 32'(reload_r);
			capture_off: rd_nxt = 32'(capture_r);
			count_off: rd_nxt = 32'(count_r);
			mode_off: rd_nxt = {30'h0, mode_r};
			irq_stat_off: rd_nxt = {30'h0, stat_r};
			irq_mask_off: rd_nxt = {30'h0, mask_r};
			default: rd_nxt = 32'h0;
		endcase
	end

	typedef enum {rd_idle, rd_fetch, rd_resp} rd_state_t;
	rd_state_t rd_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_r <= rd_idle;
			ar_addr_r <= 8'h00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= resp_okay;
		end else if (ce) begin
			case (rd_r)
				rd_idle: begin
					s_axi_arready <= s_axi_arvalid && !s_axi_arready;
					if (s_axi_arready && s_axi_arvalid) begin
						ar_addr_r <= s_axi_araddr;
						s_axi_arready <= 1'b0;
						rd_r <= rd_fetch;
					end
				end
				rd_fetch: begin
					s_axi_rvalid <= 1'b1;
					s_axi_rdata <= rd_nxt;
					s_axi_rresp <= (ar_addr_r <= irq_mask_off && ar_addr_r[1:0] == 2'h0)
						? resp_okay : resp_slverr;
					rd_r <= rd_resp;
				end
				rd_resp: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_r <= rd_idle;
					end
				end
				default: rd_r <= rd_idle;
			endcase
		end
	end

	// ====================================================
	// checks
	sequence s_trig_edge;
		ce && trig_fall && ctrl_r.external_trigger_enable && !baud_mode;
	endsequence

	a_ext_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_trig_edge and !mode_r[updown_bit]) |=> ctrl_r.external_event_flag)
		else $error("external event flag not set by trigger edge");
	a_irq_ext_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && timer2_irq_enable && ctrl_r.external_event_flag && !mode_r[updown_bit] |=> irq)
		else $error("interrupt missing for external event flag");
	a_ext_no_autoclr: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_r.external_event_flag && !mode_r[updown_bit] && !(wr_go && aw_addr_r == ctrl_off)
		|=> ctrl_r.external_event_flag)
		else $error("external event flag cleared by hardware");
	a_updown_no_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && mode_r[updown_bit] && !ctrl_r.overflow_flag && (stat_r & mask_r) == 2'h0 |=> !irq)
		else $error("interrupt from event flag in up/down mode");
	a_rx_baud_src: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && ctrl_r.rx_baud_source_select |=> baud_ticks.rx_tick == $past(ovf))
		else $error("receive baud not from timer overflow");
	a_tx_baud_src: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !ctrl_r.tx_baud_source_select |=> baud_ticks.tx_tick == $past(timer1_overflow))
		else $error("transmit baud not from timer 1");
	a_trig_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && trig_fall && (!ctrl_r.external_trigger_enable || baud_mode)
		&& ctrl_r.capture_reload_select |=> $stable(capture_r))
		else $error("trigger edge not ignored");
	a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !ctrl_r.run_control && !(wr_go && aw_addr_r == count_off) && !trig_act
		|=> $stable(count_r))
		else $error("counter moved while stopped");
	a_capture_val: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_trig_edge and ctrl_r.capture_reload_select) |=> capture_r == $past(count_r))
		else $error("capture value wrong");
	a_no_ovf_baud: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && baud_mode && !ctrl_r.overflow_flag && !(wr_go && aw_addr_r == ctrl_off)
		|=> !ctrl_r.overflow_flag)
		else $error("overflow flag set in baud mode");
endmodule : timer2_ctrl

// ==== timer2_pkg.sv ====
package timer2_pkg;
	// ====================================================
	// register map (byte addresses on the axi4-lite bus)
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] reload_off = 8'h04;
	localparam logic [7:0] capture_off = 8'h08;
	localparam logic [7:0] count_off = 8'h0C;
	localparam logic [7:0] mode_off = 8'h10;
	localparam logic [7:0] irq_stat_off = 8'h14;
	localparam logic [7:0] irq_mask_off = 8'h18;
	// ====================================================
	// control register fields
	localparam int ovf_bit = 7;
	localparam int ext_flag_bit = 6;
	localparam int rx_sel_bit = 5;
	localparam int tx_sel_bit = 4;
	localparam int trig_en_bit = 3;
	localparam int run_bit = 2;
	localparam int cnt_mode_bit = 1;
	localparam int cap_sel_bit = 0;
	localparam logic [7:0] ctrl_reset = 8'h00;
	// mode register: bit 0 up/down enable, bit 1 count direction (1 = up)
	localparam int updown_bit = 0;
	localparam int dir_bit = 1;
	localparam logic [1:0] mode_reset = 2'h2;
	// irq status: bit 0 overflow, bit 1 external event
	localparam int irq_ovf_bit = 0;
	localparam int irq_ext_bit = 1;
	// ====================================================
	// timing and bus response codes
	localparam int osc_div = 12;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef struct packed {
		logic overflow_flag;
		logic external_event_flag;
		logic rx_baud_source_select;
		logic tx_baud_source_select;
		logic external_trigger_enable;
		logic run_control;
		logic counter_mode_select;
		logic capture_reload_select;
	} timer2_control_t;

	typedef struct packed {
		logic rx_tick;
		logic tx_tick;
	} baud_ticks_t;
endpackage : timer2_pkg

// ==== fall_detect.sv ====
`timescale 1ns/1ps
module fall_detect (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic din,
	output logic fall
);
	logic prev_r;
	// pin is synchronous to aclk, so one stage of history is enough
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_r <= 1'b1;
		end else if (ce) begin
			prev_r <= din;
		end
	end
	assign fall = ce && prev_r && !din;
endmodule : fall_detect

// ==== timer2_far_side.sv ====
`timescale 1ns/1ps
module timer2_far_side (
	input wire logic aclk,
	input wire logic aresetn,
	input wire timer2_pkg::baud_ticks_t baud_ticks,
	output logic trigger_input_pin,
	output logic event_input_pin,
	output logic timer1_overflow,
	output logic [7:0] rx_seen_r,
	output logic [7:0] tx_seen_r
);
	import timer2_pkg::*;
	// ====================================================
	// pins idle high, so only a deliberate fall is an edge
	initial begin
		trigger_input_pin = 1'b1;
		event_input_pin = 1'b1;
		timer1_overflow = 1'b0;
	end
	// ====================================================
	// serial side counts the ticks it is clocked by
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_seen_r <= 8'h00;
			tx_seen_r <= 8'h00;
		end else begin
			rx_seen_r <= rx_seen_r + {7'h00, baud_ticks.rx_tick};
			tx_seen_r <= tx_seen_r + {7'h00, baud_ticks.tx_tick};
		end
	end
	// pins change just after an edge and hold two cycles per level
	task fall(input logic trig);
		@(posedge aclk);
		if (trig) begin
			trigger_input_pin <= 1'b0;
		end else begin
			event_input_pin <= 1'b0;
		end
		repeat (2) @(posedge aclk);
		trigger_input_pin <= 1'b1;
		event_input_pin <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask : fall
	task t1_pulse;
		@(posedge aclk);
		timer1_overflow <= 1'b1;
		@(posedge aclk);
		timer1_overflow <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : t1_pulse
endmodule : timer2_far_side

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	import timer2_pkg::*;
	logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq_en, irq, trig, evt, t1;
	logic [7:0] awaddr, araddr, rx_n, tx_n;
	logic [31:0] wdata, rdata, got;
	logic [1:0] bresp, rresp, rsp;
	logic [15:0] seed;
	logic [3:0] wstrb;
	int m_reg[7];
	int m_caps[$];
	int m_rx, m_tx;
	baud_ticks_t ticks;
	int fails, comparisons;
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	timer2_ctrl #(.width(16)) u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .trigger_input_pin(trig),
		.event_input_pin(evt), .timer1_overflow(t1), .timer2_irq_enable(irq_en),
		.baud_ticks(ticks), .irq(irq));
	timer2_far_side u_part (.aclk(aclk), .aresetn(aresetn), .baud_ticks(ticks),
		.trigger_input_pin(trig), .event_input_pin(evt), .timer1_overflow(t1),
		.rx_seen_r(rx_n), .tx_seen_r(tx_n));
	// ====================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task final_report;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	// slave latency is not assumed: the watchdog ends a hang
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axi_rd
	// ====================================================
	// reference model: registers as plain integers, captures as a queue
	task automatic m_write(input logic [7:0] a, input logic [31:0] d);
		case (a)
			ctrl_off: begin
				if (wstrb[0]) begin
					m_reg[0] = int'(d[7:0]);
				end
			end
			reload_off, count_off: begin
				m_reg[a[7:2]] = int'(d[15:0]);
			end
			mode_off, irq_mask_off: begin
				m_reg[a[7:2]] = int'(d[1:0]);
			end
			irq_stat_off: begin
				m_reg[5] = m_reg[5] & ~int'(d[1:0]);
			end
			default: begin
			end
		endcase
	endtask : m_write
	task automatic m_fall(input logic trig);
		logic baud, ud;
		logic [7:0] c;
		c = 8'(m_reg[0]);
		baud = c[rx_sel_bit] || c[tx_sel_bit];
		ud = m_reg[4][updown_bit];
		if (trig && c[trig_en_bit] && !baud) begin
			if (c[cap_sel_bit]) begin
				m_caps.push_back(m_reg[3]);
				m_reg[2] = m_caps[$];
			end else if (!ud) begin
				m_reg[3] = m_reg[1];
			end
			if (!ud) begin
				m_reg[0][ext_flag_bit] = 1'b1;
				m_reg[5][irq_ext_bit] = 1'b1;
			end
		end else if (!trig && c[run_bit] && c[cnt_mode_bit]) begin
			if (m_reg[3] == 65535) begin
				m_reg[3] = (!c[cap_sel_bit] || baud) ? m_reg[1] : 0;
				if (!baud) begin
					m_reg[0][ovf_bit] = 1'b1;
					m_reg[5][irq_ovf_bit] = 1'b1;
				end
				if (ud) begin
					m_reg[0][ext_flag_bit] = !m_reg[0][ext_flag_bit];
				end
				m_rx += int'(c[rx_sel_bit]);
				m_tx += int'(c[tx_sel_bit]);
			end else begin
				m_reg[3] = m_reg[3] + 1;
			end
		end
	endtask : m_fall
	function automatic logic m_irq();
		return ((m_reg[5] & m_reg[6]) != 0) || (irq_en && (m_reg[0][ovf_bit]
			|| (m_reg[0][ext_flag_bit] && !m_reg[4][updown_bit])));
	endfunction : m_irq
	task pin_fall(input logic trig);
		u_part.fall(trig);
		m_fall(trig);
	endtask : pin_fall
	task t1_tick;
		u_part.t1_pulse();
		m_rx += int'(!m_reg[0][rx_sel_bit]);
		m_tx += int'(!m_reg[0][tx_sel_bit]);
	endtask : t1_tick
	task irq_is(input logic e);
		chk(32'(irq), 32'(e));
		chk(32'(irq), 32'(m_irq()));
	endtask : irq_is
	task wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rsp);
		chk(32'(rsp), 32'(resp_okay));
		m_write(a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a, got, rsp);
		chk(32'(rsp), 32'(resp_okay));
		chk(got, e);
		chk(got, m_reg[a[7:2]]);
	endtask : rd
	// ====================================================
	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, irq_en} = '0;
		ce = 1'b1;
		wstrb = 4'hF;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		seed = 16'h0030;
		m_reg = '{default: 0};
		m_reg[4] = int'(mode_reset);
		m_rx = 0;
		m_tx = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ctrl_off, 32'h0);
		rd(mode_off, 32'h2);
		axi_rd(8'h1C, got, rsp);
		chk(32'(rsp), 32'(resp_slverr));
		chk(got, 32'h0);
		axi_wr(capture_off, 32'h1, rsp);
		chk(32'(rsp), 32'(resp_slverr));
		seed = lfsr(seed);
		wr(reload_off, {16'h0, seed});
		wr(count_off, 32'hFFFF);
		wr(ctrl_off, 32'h06);
		pin_fall(1'b0);
		rd(count_off, {16'h0, seed});
		rd(ctrl_off, 32'h86);
		rd(irq_stat_off, 32'h1);
		irq_is(1'b0);
		wr(irq_mask_off, 32'h1);
		repeat (2) @(posedge aclk);
		irq_is(1'b1);
		wr(irq_stat_off, 32'h1);
		repeat (2) @(posedge aclk);
		irq_is(1'b0);
		irq_en <= 1'b1;
		repeat (2) @(posedge aclk);
		irq_is(1'b1);
		wr(ctrl_off, 32'h06);
		repeat (2) @(posedge aclk);
		irq_is(1'b0);
		wr(count_off, 32'h1234);
		wr(ctrl_off, 32'h0F);
		pin_fall(1'b1);
		rd(capture_off, 32'h1234);
		rd(ctrl_off, 32'h4F);
		irq_is(1'b1);
		repeat (20) @(posedge aclk);
		rd(ctrl_off, 32'h4F);
		wr(mode_off, 32'h3);
		repeat (2) @(posedge aclk);
		irq_is(1'b0);
		wr(mode_off, 32'h2);
		irq_en <= 1'b0;
		wr(ctrl_off, 32'h07);
		wr(count_off, 32'h5555);
		pin_fall(1'b1);
		rd(capture_off, 32'h1234);
		rd(ctrl_off, 32'h07);
		wr(ctrl_off, 32'h00);
		// a control write without its byte strobe must not start the timer
		wstrb <= 4'h0;
		wr(ctrl_off, 32'h04);
		wstrb <= 4'hF;
		rd(ctrl_off, 32'h00);
		t1_tick();
		chk(32'(rx_n), 32'h1);
		chk(32'(tx_n), 32'(m_tx));
		wr(reload_off, 32'h0100);
		wr(count_off, 32'hFFFF);
		wr(ctrl_off, 32'h2E);
		t1_tick();
		pin_fall(1'b0);
		chk(32'(rx_n), 32'h2);
		chk(32'(tx_n), 32'h2);
		rd(count_off, 32'h0100);
		rd(ctrl_off, 32'h2E);
		wr(count_off, 32'h0200);
		pin_fall(1'b1);
		rd(count_off, 32'h0200);
		rd(ctrl_off, 32'h2E);
		wr(count_off, 32'hFFFF);
		wr(ctrl_off, 32'h16);
		pin_fall(1'b0);
		chk(32'(tx_n), 32'h3);
		chk(32'(rx_n), 32'(m_rx));
		wr(mode_off, 32'h3);
		wr(count_off, 32'hFFFF);
		wr(ctrl_off, 32'h06);
		pin_fall(1'b0);
		rd(ctrl_off, 32'hC6);
		rd(count_off, 32'h0100);
		wr(mode_off, 32'h2);
		wr(count_off, 32'h0300);
		wr(ctrl_off, 32'h0A);
		pin_fall(1'b1);
		rd(count_off, 32'h0100);
		rd(ctrl_off, 32'h4A);
		wr(count_off, 32'h0);
		wr(ctrl_off, 32'h04);
		repeat (120) @(posedge aclk);
		wr(ctrl_off, 32'h00);
		axi_rd(count_off, got, rsp);
		chk({31'h0, (got >= 32'd9 && got <= 32'd12)}, 32'h1);
		// free-running prescaler phase is not modelled, so resync the count
		m_reg[3] = int'(got);
		repeat (50) @(posedge aclk);
		rd(count_off, got);
		wr(ctrl_off, 32'h06);
		// a frozen block must miss an edge that comes and goes while ce is low
		ce <= 1'b0;
		u_part.fall(1'b0);
		ce <= 1'b1;
		rd(count_off, got);
		pin_fall(1'b0);
		rd(count_off, 32'(m_reg[3]));
		final_report();
	end
	// a stall anywhere ends the run as a failure
	initial begin
		repeat (5000) @(posedge aclk);
		fails++;
		final_report();
	end
endmodule : tb
